// ---- lane_deframer_cfg.svh ----
// Constants for the lane sample deframer: addresses, fields, resets and sizes
`ifndef LANE_DEFRAMER_CFG_SVH
`define LANE_DEFRAMER_CFG_SVH

`define LANE_COUNT 8
`define WORD_BITS 40
`define SYMBOL_BITS 10
`define OCTET_BITS 8
`define OCTETS_PER_WORD 4
`define BUF_OCTETS 12
`define MAX_FRAME_OCTETS 8
`define SLOT_COUNT 16
`define SAMPLE_BITS 16
`define FRAMES_PER_MF 32
`define MF_CNT_BITS 5
`define REG_ADDR_BITS 12
`define REG_DATA_BITS 8
`define ADDR_IFACE_PWR 12'h200
`define ADDR_LANE_PD 12'h201
`define IFACE_PD_BIT 0
`define STAT_OVERRUN_BIT 6
`define STAT_CAL_DONE_BIT 7
`define IFACE_PD_RESET 1'b1
`define LANE_PD_RESET 8'h00
`define CAL_CYCLES_DEFAULT 64
`define CAL_CNT_BITS 16
`define FIFO_DEPTH_DEFAULT 16

`endif

// ---- lane_deframer_pkg.sv ----
// Types shared by the lane sample deframer, the transmitter model and the bench
`include "lane_deframer_cfg.svh"

package lane_deframer_pkg;

	// Supported link modes, coded by their mode number
	typedef enum logic [4:0] {
		mode_00 = 5'h00,
		mode_01 = 5'h01,
		mode_02 = 5'h02,
		mode_03 = 5'h03,
		mode_04 = 5'h04,
		mode_05 = 5'h05,
		mode_06 = 5'h06,
		mode_07 = 5'h07,
		mode_09 = 5'h09,
		mode_16 = 5'h10,
		mode_17 = 5'h11,
		mode_23 = 5'h17
	} lane_mode_e;

	// Lane count, octets per frame and 12-bit packing of one mode
	typedef struct packed {
		logic known;
		logic [3:0] lanes;
		logic [3:0] octets;
		logic nibble;
	} mode_info_s;

	typedef logic [`LANE_COUNT-1:0][`WORD_BITS-1:0] lane_words_t;

	// One reassembled frame: slot c*S+s holds converter c sample s
	typedef struct packed {
		logic mf_start;
		logic [4:0] slot_count;
		logic [`SLOT_COUNT-1:0][`SAMPLE_BITS-1:0] smp;
	} sample_frame_s;

endpackage : lane_deframer_pkg

// ---- sample_fifo.sv ----
// Sample frame FIFO with registered read data and valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "lane_deframer_cfg.svh"

module sample_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `FIFO_DEPTH_DEFAULT
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);

	localparam int AW = $clog2(DEPTH);

	// Pointer wrap relies on a power of two depth
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("sample_fifo depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	logic push;
	logic load;

	// Full only when every entry holds data
	assign in_ready = (count_q != (AW+1)'(DEPTH));
	assign push = in_valid && in_ready;
	assign load = (count_q != '0) && (!out_valid || out_ready);

	// Storage needs no reset; only written entries are ever read
	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (load) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(load);
		end
	end

	// Output register holds until the consumer takes it
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			out_data <= '0;
			out_valid <= 1'b0;
		end else if (load) begin
			out_data <= mem_q[rd_ptr_q];
			out_valid <= 1'b1;
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end

	chk_fifo_hold_out: assert property (@(posedge clock) disable iff (rst)
		out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("fifo output changed while stalled");

	chk_fifo_full_flag: assert property (@(posedge clock) disable iff (rst)
		!in_ready |-> count_q == (AW+1)'(DEPTH))
		else $error("fifo refused data while not full");

	cov_fifo_full: cover property (@(posedge clock) disable iff (rst) !in_ready);

endmodule : sample_fifo

`default_nettype wire

// ---- serial_lane_sample_deframer.sv ----
// Eight-lane deserializer, link power control and frame to sample mapping
`timescale 1ns/1ps
`default_nettype none
`include "lane_deframer_cfg.svh"

// How it works
// - Two lanes, two converters, F=2: lane n is converter n, upper byte first.
// - Four lanes, four converters, F=2: lane n carries converter n, upper byte first.
// - Four lanes, two converters, S=2: lane pairs share a converter, samples interleave.
// - Eight lanes, S=4: lane k of a group carries sample k, one sample per frame.
// - One lane, 12-bit: three-octet frame packs converter 0 then 1, MSB nibble first.
// - Two lanes, four converters, 12-bit: lane 0 converters 0,1; lane 1 converters 2,3.
// - Four lanes, 12-bit, S=4: each lane packs two consecutive samples of its converter.
// - Eight lanes, 12-bit, S=8: lane k in a group packs samples 2k and 2k+1.
// - One lane, F=4: converter 0 sample then converter 1 sample, upper byte first.
// - Two lanes, F=4: lane 0 converters 0,1; lane 1 converters 2,3.
// - Three lanes, six converters, F=4: lane n carries converters 2n and 2n+1.
// - One lane, F=8: converters 0 to 3 in order, two octets each.
// - Eight identical channels turn serial streams into 40-bit words.
// - Interface stays powered down until software clears bit 0 at 0x200.
// - Lane x reads as zero in the sample frames while bit x at 0x201 is set; its lane word still updates.
// - Termination calibration runs by itself while the interface is powered up, and restarts on each write to 0x200 or 0x201.
// - Ten bits per byte, four bytes per processing word.
// - One frame is F octets, so a word yields 4/F frames.
// - Lane rate is (M/L) times NP times 10/8 times sample rate.
// - Thirty-two frames per multiframe, high-density format in every mode.
module serial_lane_sample_deframer
	import lane_deframer_pkg::*;
#(
	parameter int CAL_CYCLES = `CAL_CYCLES_DEFAULT,
	parameter int FIFO_DEPTH = `FIFO_DEPTH_DEFAULT
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [`LANE_COUNT-1:0] serial_lane_input,
	input wire logic [4:0] mode_sel,
	input wire logic reg_wr,
	input wire logic [`REG_ADDR_BITS-1:0] reg_addr,
	input wire logic [`REG_DATA_BITS-1:0] reg_wdata,
	output logic [`REG_DATA_BITS-1:0] reg_rdata,
	output lane_words_t lane_words,
	output logic lane_word_stb,
	output sample_frame_s sample_frame,
	output logic sample_valid,
	input wire logic sample_ready
);

	localparam logic [5:0] WORD_LAST = 6'(`WORD_BITS - 1);
	localparam logic [3:0] WORD_OCTETS = 4'(`OCTETS_PER_WORD);
	localparam logic [3:0] BUF_SPACE = 4'(`BUF_OCTETS - `OCTETS_PER_WORD);
	localparam logic [`CAL_CNT_BITS-1:0] CAL_LAST = `CAL_CNT_BITS'(CAL_CYCLES - 1);
	localparam int CAL_WAIT = CAL_CYCLES + 2;

	// Refuse calibration times the counter cannot hold
	if (CAL_CYCLES < 1 || CAL_CYCLES >= (1 << `CAL_CNT_BITS)) begin : g_bad_cal
		$error("CAL_CYCLES out of range");
	end

	// Lane count, octets per frame and packing of each mode
	function automatic mode_info_s mode_info(input logic [4:0] sel);
		mode_info_s mi;
		mi = '{known: 1'b1, lanes: 4'h1, octets: 4'h4, nibble: 1'b0};
		case (lane_mode_e'(sel))
			mode_00: mi.lanes = 4'h1;
			mode_01: mi.lanes = 4'h2;
			mode_02: mi.lanes = 4'h3;
			mode_03: mi = '{known: 1'b1, lanes: 4'h2, octets: 4'h2, nibble: 1'b0};
			mode_04: mi = '{known: 1'b1, lanes: 4'h4, octets: 4'h2, nibble: 1'b0};
			mode_05: mi = '{known: 1'b1, lanes: 4'h1, octets: 4'h3, nibble: 1'b1};
			mode_06: mi = '{known: 1'b1, lanes: 4'h2, octets: 4'h3, nibble: 1'b1};
			mode_07: mi = '{known: 1'b1, lanes: 4'h1, octets: 4'h8, nibble: 1'b0};
			mode_09: mi = '{known: 1'b1, lanes: 4'h4, octets: 4'h2, nibble: 1'b0};
			mode_16: mi = '{known: 1'b1, lanes: 4'h8, octets: 4'h2, nibble: 1'b0};
			mode_17: mi = '{known: 1'b1, lanes: 4'h8, octets: 4'h3, nibble: 1'b1};
			mode_23: mi = '{known: 1'b1, lanes: 4'h4, octets: 4'h3, nibble: 1'b1};
			default: mi.known = 1'b0;
		endcase
		return mi;
	endfunction : mode_info

	mode_info_s mi;
	logic iface_pd_q;
	logic [`LANE_COUNT-1:0] lane_pd_q;
	logic cfg_wr;
	logic [`CAL_CNT_BITS-1:0] cal_cnt_q;
	logic cal_done_q;
	logic link_on;
	logic [5:0] bit_cnt_q;
	logic word_end;
	logic [3:0] buf_cnt_q;
	logic [3:0] cnt_left;
	logic pop;
	logic push;
	logic append;
	logic overrun_q;
	logic fifo_ready;
	logic [`MF_CNT_BITS-1:0] mf_cnt_q;
	logic [2:0] spl;
	sample_frame_s push_frame;
	logic [`MAX_FRAME_OCTETS-1:0][`OCTET_BITS-1:0] frame_oct [`LANE_COUNT];

	assign mi = mode_info(mode_sel);

	// Register writes; power-down bit resets to 1 so the link starts off
	// interface power bit
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			iface_pd_q <= `IFACE_PD_RESET;
		end else if (reg_wr && reg_addr == `ADDR_IFACE_PWR) begin
			iface_pd_q <= reg_wdata[`IFACE_PD_BIT];
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lane_pd_q <= `LANE_PD_RESET;
		end else if (reg_wr && reg_addr == `ADDR_LANE_PD) begin
			lane_pd_q <= reg_wdata;
		end
	end

	assign cfg_wr = reg_wr && (reg_addr == `ADDR_IFACE_PWR || reg_addr == `ADDR_LANE_PD);

	// A new configuration restarts calibration so termination tracks it
	// automatic termination calibration
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cal_cnt_q <= '0;
			cal_done_q <= 1'b0;
		end else if (iface_pd_q || cfg_wr) begin
			cal_cnt_q <= '0;
			cal_done_q <= 1'b0;
		end else if (!cal_done_q) begin
			cal_cnt_q <= cal_cnt_q + 1'b1;
			cal_done_q <= (cal_cnt_q == CAL_LAST);
		end
	end

	// no lane data until powered and calibrated
	assign link_on = !iface_pd_q && cal_done_q;

	// Status readback, one cycle after the address
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			reg_rdata <= '0;
		end else begin
			case (reg_addr)
				`ADDR_IFACE_PWR: begin
					reg_rdata <= '0;
					reg_rdata[`IFACE_PD_BIT] <= iface_pd_q;
					reg_rdata[`STAT_OVERRUN_BIT] <= overrun_q;
					reg_rdata[`STAT_CAL_DONE_BIT] <= cal_done_q;
				end
				`ADDR_LANE_PD: reg_rdata <= lane_pd_q;
				default: reg_rdata <= '0;
			endcase
		end
	end

	// Shared word boundary; lanes are assumed aligned to each other
	// four ten-bit bytes per word
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bit_cnt_q <= '0;
		end else if (!link_on || word_end) begin
			bit_cnt_q <= '0;
		end else begin
			bit_cnt_q <= bit_cnt_q + 1'b1;
		end
	end

	assign word_end = link_on && (bit_cnt_q == WORD_LAST);

	// Word strobe marks a fresh set of lane words
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lane_word_stb <= 1'b0;
		end else begin
			lane_word_stb <= word_end;
		end
	end

	// Buffer level: pops take a frame, appends add a word
	assign pop = link_on && (buf_cnt_q >= mi.octets) && fifo_ready;
	assign cnt_left = pop ? buf_cnt_q - mi.octets : buf_cnt_q;
	assign append = lane_word_stb && link_on && (cnt_left <= BUF_SPACE);
	assign push = pop && mi.known;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			buf_cnt_q <= '0;
		end else if (!link_on) begin
			buf_cnt_q <= '0;
		end else begin
			buf_cnt_q <= cnt_left + (append ? WORD_OCTETS : 4'h0);
		end
	end

	// Sticky drop flag; a stalled consumer loses words, not frames
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			overrun_q <= 1'b0;
		end else if (iface_pd_q) begin
			overrun_q <= 1'b0;
		end else if (lane_word_stb && !append) begin
			overrun_q <= 1'b1;
		end
	end

	for (genvar g = 0; g < `LANE_COUNT; g++) begin : g_lane
		logic [2:0] sync_q;
		logic [`WORD_BITS-1:0] shift_q;
		logic [`WORD_BITS-1:0] word_q;
		logic [`BUF_OCTETS*`OCTET_BITS-1:0] buf_q;
		logic [`BUF_OCTETS*`OCTET_BITS-1:0] buf_d;
		logic [`OCTETS_PER_WORD*`OCTET_BITS-1:0] word_oct;

		// Three-stage synchroniser; a bit lasts one clock, so no agreement filter
		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				sync_q <= '0;
			end else begin
				sync_q <= {sync_q[1:0], serial_lane_input[g]};
			end
		end

		// Serial to 40-bit word, first bit ends up at the top
		// byte rate is bit rate over ten
		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				shift_q <= '0;
				word_q <= '0;
			end else if (link_on) begin
				shift_q <= {shift_q[`WORD_BITS-2:0], sync_q[2]};
				if (word_end) begin
					word_q <= {shift_q[`WORD_BITS-2:0], sync_q[2]};
				end
			end
		end

		assign lane_words[g] = word_q;

		// Octet i of a word is the data part of symbol i, first symbol lowest
		always_comb begin
			word_oct = '0;
			for (int i = 0; i < `OCTETS_PER_WORD; i++) begin
				word_oct[i*`OCTET_BITS +: `OCTET_BITS] =
					word_q[(`OCTETS_PER_WORD-1-i)*`SYMBOL_BITS +: `OCTET_BITS];
			end
		end

		// Octet buffer: drop a frame from the bottom, add the word above the rest
		always_comb begin
			buf_d = pop ? (buf_q >> {mi.octets, 3'h0}) : buf_q;
			if (append) begin
				buf_d = buf_d | ({64'h0, word_oct} << {cnt_left, 3'h0});
			end
		end

		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				buf_q <= '0;
			end else if (!link_on) begin
				buf_q <= '0;
			end else begin
				buf_q <= buf_d;
			end
		end

		// off lanes and lanes beyond the mode read as zero
		always_comb begin
			if (lane_pd_q[g] || g >= int'(mi.lanes)) begin
				frame_oct[g] = '0;
			end else begin
				frame_oct[g] = buf_q[`MAX_FRAME_OCTETS*`OCTET_BITS-1:0];
			end
		end
	end

	// Samples per lane per frame: two for 12-bit packing, F/2 otherwise
	assign spl = mi.nibble ? 3'h2 : mi.octets[3:1];

	// Lane l sample k lands in slot l*spl+k in every mode
	// converter per lane
	always_comb begin
		int idx;
		idx = 0;
		push_frame = '0;
		push_frame.slot_count = 5'(int'(mi.lanes) * int'(spl));
		push_frame.mf_start = (mf_cnt_q == '0);
		for (int l = 0; l < `LANE_COUNT; l++) begin
			for (int k = 0; k < `OCTETS_PER_WORD; k++) begin
				idx = l * int'(spl) + k;
				if (k < int'(spl) && idx < `SLOT_COUNT) begin
					if (mi.nibble && k == 0) begin
						push_frame.smp[idx] = {4'h0, frame_oct[l][0], frame_oct[l][1][7:4]};
					end else if (mi.nibble) begin
						push_frame.smp[idx] = {4'h0, frame_oct[l][1][3:0], frame_oct[l][2]};
					end else begin
						push_frame.smp[idx] = {frame_oct[l][2*k], frame_oct[l][2*k+1]};
					end
				end
			end
		end
	end

	// Multiframe position of each delivered frame
	// thirty-two frames per multiframe
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mf_cnt_q <= '0;
		end else if (!link_on) begin
			mf_cnt_q <= '0;
		end else if (push) begin
			mf_cnt_q <= mf_cnt_q + 1'b1;
		end
	end

	// Frame buffer toward the datapath; a full buffer stalls the pops
	sample_fifo #(
		.WIDTH($bits(sample_frame_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.rst(rst),
		.in_data(push_frame),
		.in_valid(push),
		.in_ready(fifo_ready),
		.out_data(sample_frame),
		.out_valid(sample_valid),
		.out_ready(sample_ready)
	);

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	chk_pd_blocks_frames: assert property (iface_pd_q |-> !push && !lane_word_stb)
		else $error("frame moved while interface powered down");

	chk_cal_restart: assert property ($rose(iface_pd_q) |=> !cal_done_q && !link_on)
		else $error("calibration not cleared at power down");

	chk_cal_finish: assert property (!iface_pd_q && !cal_done_q && cal_cnt_q == '0
		&& !cfg_wr ##1 (!iface_pd_q && !cfg_wr)[*2] |-> ##[0:CAL_WAIT] cal_done_q)
		else $error("calibration did not finish");

	chk_word_period: assert property (lane_word_stb |-> $past(bit_cnt_q) == WORD_LAST)
		else $error("word strobe off the 40-bit boundary");

	chk_frame_pop: assert property (push |-> buf_cnt_q >= mi.octets && fifo_ready)
		else $error("frame taken before F octets buffered");

	chk_mf_start: assert property (push && push_frame.mf_start |=> mf_cnt_q == `MF_CNT_BITS'(1))
		else $error("multiframe start not at frame 0 only");

	chk_lane_masked: assert property (push && lane_pd_q[0] |-> frame_oct[0] == '0)
		else $error("powered-down lane contributed data");

	chk_map_bytes: assert property (push && !mi.nibble && !lane_pd_q[0]
		|-> push_frame.smp[0] == {buf_q_low(0), buf_q_low(1)})
		else $error("upper byte not taken from first octet");

	chk_map_nibble: assert property (push && mi.nibble && !lane_pd_q[0]
		|-> push_frame.smp[1][11:8] == frame_oct[0][1][3:0])
		else $error("second 12-bit sample nibble order wrong");

	function automatic logic [`OCTET_BITS-1:0] buf_q_low(input int o);
		return g_lane[0].buf_q[o*`OCTET_BITS +: `OCTET_BITS];
	endfunction : buf_q_low

	cov_mode17_frame: cover property (push && mi.nibble && mi.lanes == 4'h8);
	cov_mode7_frame: cover property (push && mi.octets == 4'h8);
	cov_cal_done: cover property ($rose(cal_done_q));
	cov_overrun: cover property ($rose(overrun_q));

endmodule : serial_lane_sample_deframer

`default_nettype wire

// ---- placeholder_end.sv ----
// Intentionally empty compilation unit
`timescale 1ns/1ps

// ---- lane_tx_model.sv ----
// Transmitter model that shifts one 40-bit word per lane out a bit per clock
`timescale 1ns/1ps
`default_nettype none
`include "lane_deframer_cfg.svh"

module lane_tx_model
	import lane_deframer_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic run,
	input wire lane_words_t word_in,
	output logic word_take,
	output logic [`LANE_COUNT-1:0] lanes_out
);
	lane_words_t sh_q;
	logic [5:0] cnt_q;

	// forty bits a word, first bit is bit 39
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_q <= 6'h00;
			word_take <= 1'b0;
			lanes_out <= 8'h55;
			sh_q <= '0;
		end else if (!run) begin
			// Idle lines toggle so a stale bit is never mistaken for data
			lanes_out <= ~lanes_out;
			cnt_q <= 6'h00;
			word_take <= 1'b0;
		end else begin
			for (int l = 0; l < `LANE_COUNT; l++) begin
				lanes_out[l] <= (cnt_q == 6'h00) ? word_in[l][39] : sh_q[l][39];
				sh_q[l] <= (cnt_q == 6'h00) ? {word_in[l][38:0], 1'b0} : {sh_q[l][38:0], 1'b0};
			end
			word_take <= (cnt_q == 6'h00);
			cnt_q <= (cnt_q == 6'h27) ? 6'h00 : cnt_q + 6'h01;
		end
	end
endmodule : lane_tx_model

`default_nettype wire

// ---- serial_lane_sample_deframer_test.sv ----
// Self-checking bench: register access, lane words and sample mapping per mode
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e, m) begin samples_checked++; if ((a) !== (e)) begin failures++; $display("CHECK FAILED %0t %s", $time, m); end end

module serial_lane_sample_deframer_test;
	import lane_deframer_pkg::*;
	localparam int CAL = 4;
	localparam int NW = 16;
	localparam logic [4:0] MC[12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
		5'h09, 5'h10, 5'h11, 5'h17};
	localparam int ML[12] = '{1, 2, 3, 2, 4, 1, 2, 1, 4, 8, 8, 4};
	localparam int MF[12] = '{4, 4, 4, 2, 2, 3, 3, 8, 2, 2, 3, 3};
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [4:0] mode_sel = 5'h00;
	logic reg_wr = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0] reg_wdata = 8'h00;
	logic sample_ready = 1'b0;
	logic [7:0] reg_rdata;
	lane_words_t lane_words;
	lane_words_t tx_word;
	logic lane_word_stb;
	sample_frame_s sample_frame;
	logic sample_valid;
	logic word_take;
	logic run = 1'b0;
	logic [7:0] lanes;
	logic [7:0] oct[8][64];
	logic [7:0] pd = 8'h00;
	logic [7:0] seed = 8'h61;
	logic chk = 1'b0;
	logic rdy_en = 1'b0;
	int nl, nf, pp, nib, nfr, fidx, widx, wcnt, cycles;
	int failures = 0;
	int samples_checked = 0;

	always #50 clock = ~clock;

	lane_tx_model tx (.clock(clock), .rst(rst), .run(run), .word_in(tx_word),
		.word_take(word_take), .lanes_out(lanes));

	serial_lane_sample_deframer #(.CAL_CYCLES(CAL), .FIFO_DEPTH(16)) dut (.clock(clock),
		.rst(rst), .serial_lane_input(lanes), .mode_sel(mode_sel), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.lane_words(lane_words), .lane_word_stb(lane_word_stb), .sample_frame(sample_frame),
		.sample_valid(sample_valid), .sample_ready(sample_ready));

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	// Past the stored words the model sends inverted copies, never checked
	function automatic logic [39:0] word_of(input int l, input int w);
		int b;
		b = 4 * (w % NW);
		word_of = {2'b10, oct[l][b], 2'b10, oct[l][b+1], 2'b10, oct[l][b+2], 2'b10, oct[l][b+3]};
		if (w >= NW) word_of = ~word_of;
	endfunction : word_of

	function automatic logic [15:0] exp_smp(input int f, input int s);
		int l, k, b;
		l = s / pp;
		k = s % pp;
		b = f * nf;
		if (l >= nl || pd[l]) return 16'h0000;
		if (nib != 0) begin
			if (k == 0) return {4'h0, oct[l][b], oct[l][b+1][7:4]};
			return {4'h0, oct[l][b+1][3:0], oct[l][b+2]};
		end
		return {oct[l][b+2*k], oct[l][b+2*k+1]};
	endfunction : exp_smp

	task automatic test_done();
		$display("failures %0d samples_checked %0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_addr <= a;
		@(posedge clock);
		#1;
		`CHK(reg_rdata, e, "register read")
	endtask : rd

	always_comb begin
		for (int l = 0; l < 8; l++) tx_word[l] = word_of(l, widx);
	end

	// Ready is random once the stall phase is over
	always @(posedge clock) begin
		seed <= lfsr(seed);
		sample_ready <= rdy_en & seed[0];
		if (word_take === 1'b1) widx++;
		cycles++;
		if (cycles == 30000) begin
			failures++;
			$display("CHECK FAILED %0t timeout", $time);
			test_done();
		end
	end

	always @(posedge clock) begin
		if (chk && lane_word_stb === 1'b1 && wcnt < NW) begin
			for (int l = 0; l < 8; l++) if (!pd[l]) `CHK(lane_words[l], word_of(l, wcnt), "lane word")
			wcnt++;
		end
	end

	// each of the first nfr delivered frames against the model
	always @(posedge clock) begin
		if (chk && sample_valid === 1'b1 && sample_ready === 1'b1 && fidx < nfr) begin
			`CHK(sample_frame.mf_start, 1'(fidx % 32 == 0), "multiframe start")
			`CHK(sample_frame.slot_count, 5'(nl * pp), "slot count")
			for (int s = 0; s < 16; s++) `CHK(sample_frame.smp[s], exp_smp(fidx, s), "sample")
			fidx++;
		end
	end

	initial begin
		for (int i = 0; i < 12; i++) begin
			nl = ML[i];
			nf = MF[i];
			nib = (nf == 3);
			pp = nib ? 2 : nf / 2;
			nfr = 64 / nf;
			for (int l = 0; l < 8; l++) begin
				for (int j = 0; j < 64; j++) begin
					seed = lfsr(seed);
					oct[l][j] = seed;
				end
				// 11-bit samples carry a zero low bit
				for (int j = 0; j < 21 && nib && MC[i] > 5'h06; j++) begin
					oct[l][3*j+1][4] = 1'b0;
					oct[l][3*j+2][0] = 1'b0;
				end
			end
			pd = 8'(8'hFF << nl);
			if (nl > 1 && i % 2 == 1) pd[1] = 1'b1;
			mode_sel <= MC[i];
			rst <= 1'b1;
			repeat (3) @(posedge clock);
			rst <= 1'b0;
			// powered down out of reset, unmapped reads give zero
			rd(12'h200, 8'h01);
			rd(12'h202, 8'h00);
			wr(12'h201, pd);
			rd(12'h201, pd);
			fidx = 0;
			widx = 0;
			wcnt = 0;
			chk = 1'b1;
			rdy_en <= 1'b0;
			wr(12'h200, 8'h00);
			// First bit needs four edges to reach the shifter as the link comes on
			repeat (CAL - 4) @(posedge clock);
			run <= 1'b1;
			// Consumer stalls for eight words so the buffer backs up
			repeat (320) @(posedge clock);
			rdy_en <= 1'b1;
			for (int n = 0; n < 2000 && fidx < nfr; n++) @(posedge clock);
			`CHK(fidx, nfr, "frame count")
			// calibration done, no overrun, interface up
			rd(12'h200, 8'h80);
			chk = 1'b0;
			run <= 1'b0;
		end
		test_done();
	end
endmodule : serial_lane_sample_deframer_test

`default_nettype wire
